//--- fan_defs.svh
`ifndef FAN_DEFS_SVH
`define FAN_DEFS_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define CLK_HZ              50000000
`define PWM_CARRIER_HZ      25000
`define CARRIER_CYC         (`CLK_HZ / `PWM_CARRIER_HZ)
`define SLEEP_TIME_US       1000
`define SLEEP_CYC           ((`CLK_HZ / 1000000) * `SLEEP_TIME_US)
`define CMD_FMIN_HZ         15000
// Timeout a quarter above the slowest legal command period
`define CMD_PERIOD_MAX_CYC  ((`CLK_HZ * 5) / (`CMD_FMIN_HZ * 4))

// ==========================================================================
// Duty decoding
// ==========================================================================
`define DUTY_FULL_CODE      9'h1FF
`define DUTY_ZERO_CODE      9'h000
`define DUTY_MIN_CODE       9'h033
`define STBY_NUM            32'h0000_0026
`define STBY_DEN            32'h0000_2710
`define FILTER_SHIFT_DEF    4

// ==========================================================================
// Handoff speed, tenths of Hz
// ==========================================================================
`define HANDOFF_STEP_DHZ    11'h07D
`define HANDOFF_LOW_DHZ     11'h36B

// ==========================================================================
// Register map (byte offsets) and reset values
// ==========================================================================
`define REG_CTRL            4'h0
`define REG_STATUS          4'h4
`define REG_DUTY            4'h8
`define REG_HANDOFF         4'hC
`define CTRL_DRIVE_EN_BIT   0
`define CTRL_RESET          1'b1

`endif

//--- fan_pkg.sv
package fan_pkg;

    typedef enum logic [3:0] {
        ST_INIT    = 4'b0001,
        ST_RUN     = 4'b0010,
        ST_STANDBY = 4'b0100,
        ST_SLEEP   = 4'b1000
    } drive_state_e;

endpackage : fan_pkg

//--- duty_meter.sv
`timescale 1ns/10ps
`default_nettype none
`include "fan_defs.svh"

module duty_meter #(
    parameter int CW         = 13,
    parameter int PERIOD_MAX = `CMD_PERIOD_MAX_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_in,
    output logic [8:0]      duty_code,
    output logic            duty_valid,
    output logic            below_standby
);
    localparam int NB = CW + 9;

    initial begin
        if (PERIOD_MAX >= (1 << CW) || PERIOD_MAX < 2)
            $error("duty_meter: PERIOD_MAX does not fit CW");
    end

    logic          cmd_d_reg,  cmd_d_next;
    logic [CW-1:0] per_reg,    per_next;
    logic [CW-1:0] hi_reg,     hi_next;
    logic [CW-1:0] den_reg,    den_next;
    logic [CW:0]   rem_reg,    rem_next;
    logic [NB-1:0] num_reg,    num_next;
    logic [4:0]    cnt_reg,    cnt_next;
    logic [8:0]    duty_next;
    logic          valid_next, stby_next;

    // ======================================================================
    // High time against period, then restoring divide by the period
    // ======================================================================
    always_comb begin
        logic [CW:0]   trial;
        logic [31:0]   lhs;
        logic [31:0]   rhs;
        trial      = '0;
        lhs        = 32'(hi_reg) * `STBY_DEN;
        rhs        = 32'(per_reg) * `STBY_NUM;
        cmd_d_next = cmd_in;
        per_next   = per_reg + 1'b1;
        hi_next    = hi_reg + CW'(cmd_in);
        den_next   = den_reg;
        rem_next   = rem_reg;
        num_next   = num_reg;
        cnt_next   = cnt_reg;
        duty_next  = duty_code;
        valid_next = 1'b0;
        stby_next  = below_standby;
        if (cnt_reg != 5'h00) begin
            trial    = {rem_reg[CW-1:0], num_reg[NB-1]};
            num_next = {num_reg[NB-2:0], 1'b0};
            if (trial >= {1'b0, den_reg}) begin
                rem_next    = trial - {1'b0, den_reg};
                num_next[0] = 1'b1;
            end else begin
                rem_next = trial;
            end
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == 5'h01) begin
                duty_next  = (num_next[NB-1:9] != '0) ? `DUTY_FULL_CODE
                                                     : num_next[8:0];
                valid_next = 1'b1;
            end
        end
        if (cmd_in && !cmd_d_reg) begin
            per_next  = CW'(1);
            hi_next   = CW'(1);
            den_next  = per_reg;
            num_next  = {hi_reg, 9'h000};
            rem_next  = '0;
            cnt_next  = 5'(NB);
            stby_next = (lhs < rhs);
        end else if (per_reg >= CW'(PERIOD_MAX)) begin
            per_next   = '0;
            hi_next    = '0;
            cnt_next   = '0;
            duty_next  = cmd_in ? `DUTY_FULL_CODE : `DUTY_ZERO_CODE;
            valid_next = 1'b1;
            stby_next  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_d_reg     <= 1'b1;
            per_reg       <= '0;
            hi_reg        <= '0;
            den_reg       <= '0;
            rem_reg       <= '0;
            num_reg       <= '0;
            cnt_reg       <= '0;
            duty_code     <= '0;
            duty_valid    <= 1'b0;
            below_standby <= 1'b0;
        end else begin
            cmd_d_reg     <= cmd_d_next;
            per_reg       <= per_next;
            hi_reg        <= hi_next;
            den_reg       <= den_next;
            rem_reg       <= rem_next;
            num_reg       <= num_next;
            cnt_reg       <= cnt_next;
            duty_code     <= duty_next;
            duty_valid    <= valid_next;
            below_standby <= stby_next;
        end
    end

endmodule : duty_meter
`default_nettype wire

//--- phase_pwm.sv
`timescale 1ns/10ps
`default_nettype none
`include "fan_defs.svh"

module phase_pwm #(
    parameter int CARRIER = `CARRIER_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [6:0] angle,
    input  wire logic [8:0] amp,
    input  wire logic       reverse,
    input  wire logic       enable,
    output logic [2:0]      pwm,
    output logic [2:0]      oe
);
    initial begin
        if (CARRIER < 2 || CARRIER > 2048)
            $error("phase_pwm: CARRIER out of range");
    end

    // Quarter sine, 25 points of 3.75 degrees, scaled to 127
    localparam logic [199:0] QSIN = {
        8'h7F, 8'h7F, 8'h7E, 8'h7D, 8'h7B, 8'h78, 8'h75, 8'h72, 8'h6E,
        8'h6A, 8'h65, 8'h5F, 8'h5A, 8'h54, 8'h4D, 8'h47, 8'h40, 8'h38,
        8'h31, 8'h29, 8'h21, 8'h19, 8'h11, 8'h08, 8'h00};

    // Sine offset by 127, angle in 96 steps per electrical turn
    function automatic logic [7:0] sine_off(input logic [6:0] a);
        logic [7:0] mag;
        mag = '0;
        if (a < 7'd24)      mag = QSIN[8*a +: 8];
        else if (a < 7'd48) mag = QSIN[8*(7'd48 - a) +: 8];
        else if (a < 7'd72) mag = QSIN[8*(a - 7'd48) +: 8];
        else                mag = QSIN[8*(7'd96 - a) +: 8];
        return (a < 7'd48) ? 8'(8'h7F + mag) : 8'(8'h7F - mag);
    endfunction : sine_off

    function automatic logic [6:0] wrap96(input logic [6:0] a, input logic [6:0] d);
        logic [7:0] s;
        s = {1'b0, a} + {1'b0, d};
        return (s >= 8'd96) ? 7'(s - 8'd96) : s[6:0];
    endfunction : wrap96

    logic [10:0] cnt_reg, cnt_next;
    logic [2:0]  pwm_next;
    logic [2:0]  oe_next;

    // ======================================================================
    // Carrier and per-phase compare
    // ======================================================================
    always_comb begin
        logic [7:0]  s [3];
        logic [7:0]  mn;
        logic [16:0] prod;
        s[0] = sine_off(angle);
        s[1] = sine_off(wrap96(angle, reverse ? 7'd32 : 7'd64));
        s[2] = sine_off(wrap96(angle, reverse ? 7'd64 : 7'd32));
        mn   = (s[0] < s[1]) ? s[0] : s[1];
        mn   = (s[2] < mn) ? s[2] : mn;
        prod = '0;
        cnt_next = (cnt_reg >= 11'(CARRIER - 1)) ? 11'h000 : cnt_reg + 1'b1;
        for (int i = 0; i < 3; i++) begin
            // Lowest phase sits at zero: clamp-to-min adds third harmonic
            prod        = 17'(s[i] - mn) * 17'(amp);
            pwm_next[i] = enable && ({1'b0, cnt_reg} < prod[16:6]);
        end
        oe_next = {3{enable}};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            pwm     <= '0;
            oe      <= '0;
        end else begin
            cnt_reg <= cnt_next;
            pwm     <= pwm_next;
            oe      <= oe_next;
        end
    end

endmodule : phase_pwm
`default_nettype wire

//--- fan_speed_command_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "fan_defs.svh"

module fan_speed_command_decoder #(
    parameter int          FILTER_SHIFT = `FILTER_SHIFT_DEF,
    parameter int unsigned SLEEP_CYC    = `SLEEP_CYC,
    parameter logic [10:0] LOW_BAND_DHZ = `HANDOFF_LOW_DHZ
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        command_in,
    input  wire logic        rotation_select,
    input  wire logic [7:0]  handoff_level,
    input  wire logic        motor_below_10hz,
    input  wire logic [6:0]  rotor_angle,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic [2:0]       phase_pwm_out,
    output logic [2:0]       phase_oe,
    output logic             standby,
    output logic             sleep,
    output logic             init_req,
    output logic [8:0]       amplitude,
    output logic [10:0]      handoff_speed,
    output logic             reverse_dir
);
    localparam int AW = 9 + FILTER_SHIFT;

    initial begin
        if (FILTER_SHIFT < 0 || FILTER_SHIFT > 12)
            $error("fan_speed_command_decoder: FILTER_SHIFT out of range");
        if (SLEEP_CYC < 1 || SLEEP_CYC > 65535)
            $error("fan_speed_command_decoder: SLEEP_CYC out of range");
    end

    // ======================================================================
    // Duty measurement
    // ======================================================================
    logic [8:0] duty_code;
    logic       duty_valid;
    logic       below_standby;

    duty_meter #(
        .CW         (13),
        .PERIOD_MAX (`CMD_PERIOD_MAX_CYC)
    ) u_meter (
        .clk           (clk),
        .rst_n         (rst_n),
        .cmd_in        (command_in),
        .duty_code     (duty_code),
        .duty_valid    (duty_valid),
        .below_standby (below_standby)
    );

    // ======================================================================
    // Mode sequencing
    // ======================================================================
    fan_pkg::drive_state_e state_reg, state_next;
    logic [15:0]           low_cnt_reg, low_cnt_next;
    logic                  dir_reg, dir_next;
    logic                  sleep_ok;

    // Sleep timer runs on the raw level so it also sees a floating-low pin
    assign sleep_ok = (low_cnt_reg == 16'(SLEEP_CYC)) && motor_below_10hz;

    always_comb begin
        state_next   = state_reg;
        dir_next     = dir_reg;
        low_cnt_next = command_in ? 16'h0000
                     : (low_cnt_reg == 16'(SLEEP_CYC)) ? low_cnt_reg
                     : low_cnt_reg + 1'b1;
        case (state_reg)
            fan_pkg::ST_INIT: begin
                // Direction caught once per start-up, host sets it beforehand
                dir_next   = rotation_select;
                state_next = fan_pkg::ST_RUN;
            end
            fan_pkg::ST_RUN: begin
                if (sleep_ok)
                    state_next = fan_pkg::ST_SLEEP;
                else if (below_standby)
                    state_next = fan_pkg::ST_STANDBY;
            end
            fan_pkg::ST_STANDBY: begin
                if (sleep_ok)
                    state_next = fan_pkg::ST_SLEEP;
                else if (!below_standby)
                    state_next = fan_pkg::ST_RUN;
            end
            fan_pkg::ST_SLEEP: begin
                if (command_in)
                    state_next = fan_pkg::ST_INIT;
            end
            default: state_next = fan_pkg::ST_INIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= fan_pkg::ST_INIT;
            low_cnt_reg <= '0;
            dir_reg     <= 1'b0;
        end else begin
            state_reg   <= state_next;
            low_cnt_reg <= low_cnt_next;
            dir_reg     <= dir_next;
        end
    end

    // ======================================================================
    // Amplitude filter
    // ======================================================================
    logic [AW-1:0] acc_reg, acc_next;
    logic [8:0]    target;

    always_comb begin
        if (duty_code == `DUTY_ZERO_CODE)
            target = `DUTY_ZERO_CODE;
        else if (duty_code < `DUTY_MIN_CODE)
            target = `DUTY_MIN_CODE;
        else
            target = duty_code;
        acc_next = acc_reg;
        if (state_reg == fan_pkg::ST_SLEEP)
            acc_next = '0;
        else if (duty_valid)
            acc_next = AW'(acc_reg - (acc_reg >> FILTER_SHIFT) + AW'(target));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

    // ======================================================================
    // Handoff band
    // ======================================================================
    logic [10:0] handoff_next;

    always_comb begin
        if (handoff_level[7:4] == 4'h0)
            handoff_next = LOW_BAND_DHZ;
        else
            handoff_next = 11'(handoff_level[7:4] * `HANDOFF_STEP_DHZ);
    end

    // ======================================================================
    // Register file
    // ======================================================================
    logic        drive_en_reg, drive_en_next;
    logic [31:0] rdata_next;

    always_comb begin
        drive_en_next = drive_en_reg;
        if (reg_wr && reg_addr == `REG_CTRL)
            drive_en_next = reg_wdata[`CTRL_DRIVE_EN_BIT];
        rdata_next = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:    rdata_next = {31'h0000_0000, drive_en_reg};
                `REG_STATUS:  rdata_next = {26'h000_0000, below_standby, dir_reg,
                                            state_reg};
                `REG_DUTY:    rdata_next = {7'h00, duty_code, 7'h00, amplitude};
                `REG_HANDOFF: rdata_next = {12'h000, handoff_level[7:4], 5'h00,
                                            handoff_speed};
                default:      rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_en_reg <= `CTRL_RESET;
            reg_rdata    <= '0;
        end else begin
            drive_en_reg <= drive_en_next;
            reg_rdata    <= rdata_next;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    logic drive_on;

    // Phases float outside run; speed follows amplitude only
    // Next state keeps the registered enables in step with the mode flags
    assign drive_on = drive_en_reg && state_next == fan_pkg::ST_RUN;

    phase_pwm #(
        .CARRIER (`CARRIER_CYC)
    ) u_pwm (
        .clk     (clk),
        .rst_n   (rst_n),
        .angle   (rotor_angle),
        .amp     (amplitude),
        .reverse (dir_reg),
        .enable  (drive_on),
        .pwm     (phase_pwm_out),
        .oe      (phase_oe)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            standby       <= 1'b0;
            sleep         <= 1'b0;
            init_req      <= 1'b0;
            amplitude     <= '0;
            handoff_speed <= '0;
            reverse_dir   <= 1'b0;
        end else begin
            standby       <= (state_next == fan_pkg::ST_STANDBY);
            sleep         <= (state_next == fan_pkg::ST_SLEEP);
            // Pulse the cycle after init, so reset release requests it as well
            init_req      <= (state_reg == fan_pkg::ST_INIT);
            amplitude     <= acc_next[AW-1:FILTER_SHIFT];
            handoff_speed <= handoff_next;
            reverse_dir   <= dir_next;
        end
    end

endmodule : fan_speed_command_decoder
`default_nettype wire

//--- fan_speed_command_decoder_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port-level checks of the command decoder
// ==========================================================================
module fan_speed_command_decoder_chk #(
    parameter int unsigned SLEEP_CYC    = 200,
    parameter logic [10:0] LOW_BAND_DHZ = 11'h36B
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        command_in,
    input wire logic        motor_below_10hz,
    input wire logic [7:0]  handoff_level,
    input wire logic [2:0]  phase_pwm_out,
    input wire logic [2:0]  phase_oe,
    input wire logic        standby,
    input wire logic        sleep,
    input wire logic        init_req,
    input wire logic [10:0] handoff_speed,
    input wire logic        reverse_dir
);
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;

    // Saturates so a long sleep never wraps back below the entry time
    always_comb begin
        low_cnt_next = command_in ? 16'h0000 : low_cnt_reg + {15'h0000, ~&low_cnt_reg};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 16'h0000;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    oe_needs_run_a: assert property (phase_oe != 3'h0 |-> !standby && !sleep)
        else $error("phases driven outside run");
    modes_apart_a: assert property (!(standby && sleep))
        else $error("standby and sleep together");
    one_low_a: assert property (phase_pwm_out != 3'h7)
        else $error("no phase held at zero");
    sleep_late_a: assert property ($rose(sleep) |-> low_cnt_reg >= SLEEP_CYC - 1)
        else $error("sleep entered before low time ran out");
    sleep_slow_a: assert property ($rose(sleep) |-> $past(motor_below_10hz))
        else $error("sleep entered with fast motor");
    sleep_holds_a: assert property ((sleep && !command_in)[*4] |=> sleep)
        else $error("sleep left while command low");
    wake_init_a: assert property (sleep && $rose(command_in) |-> ##[1:4] init_req)
        else $error("wake without power-on sequence");
    init_pulse_a: assert property (init_req |=> !init_req)
        else $error("init request longer than one cycle");
    dir_frozen_a: assert property (
        !init_req && !$past(init_req) && !$past(init_req, 2) |-> $stable(reverse_dir))
        else $error("direction changed outside start-up");
    handoff_map_a: assert property ($past(rst_n) |-> handoff_speed ==
        (($past(handoff_level[7:4]) == 4'h0) ?
        LOW_BAND_DHZ : 11'($past(handoff_level[7:4])) * 11'h07D))
        else $error("handoff speed does not match band");

    cover property ($rose(sleep));
    cover property ($rose(standby));
    cover property ($rose(reverse_dir));
endmodule : fan_speed_command_decoder_chk

bind fan_speed_command_decoder fan_speed_command_decoder_chk #(
    .SLEEP_CYC   (SLEEP_CYC),
    .LOW_BAND_DHZ(LOW_BAND_DHZ)
) chk (
    .clk, .rst_n, .command_in, .motor_below_10hz, .handoff_level, .phase_pwm_out,
    .phase_oe, .standby, .sleep, .init_req, .handoff_speed, .reverse_dir
);
`default_nettype wire

//--- fan_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Host driving the speed command pin
// ==========================================================================
module fan_host_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] period,
    input  wire logic [15:0] high_cnt,
    input  wire logic        float_en,
    output logic             command_in
);
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;

    // Period of 500 cycles is 100 kHz, top of the accepted span
    always_comb begin
        cnt_next = (cnt_reg + 16'h0001 >= period) ? 16'h0000 : cnt_reg + 16'h0001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg    <= 16'h0000;
            command_in <= 1'b1;
        end else begin
            cnt_reg    <= cnt_next;
            // Released pin floats up through the pull-up
            command_in <= float_en | (cnt_reg < high_cnt);
        end
    end
endmodule : fan_host_model
`default_nettype wire

//--- fan_speed_command_decoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error at %0t: got %0h want %0h", $time, g, e); \
    end \
end

module fan_speed_command_decoder_bench;
    localparam logic [10:0] LOW = 11'h36B;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        command_in;
    logic        rotation_select = 1'b0;
    logic [7:0]  handoff_level = 8'h00;
    logic        motor_below_10hz = 1'b0;
    logic [6:0]  rotor_angle = 7'h00;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0]  phase_pwm_out;
    logic [2:0]  phase_oe;
    logic        standby;
    logic        sleep;
    logic        init_req;
    logic [8:0]  amplitude;
    logic [10:0] handoff_speed;
    logic        reverse_dir;
    logic [15:0] high_cnt = 16'h01F4;
    logic        float_en = 1'b0;
    logic        hold_angle = 1'b0;
    logic [31:0] rd;
    logic        p;
    int          mismatches = 0;
    int          checks_done = 0;
    int          h, g, k, t;

    fan_speed_command_decoder #(
        .FILTER_SHIFT(2),
        .SLEEP_CYC   (200),
        .LOW_BAND_DHZ(LOW)
    ) dut (
        .clk, .rst_n, .command_in, .rotation_select, .handoff_level, .motor_below_10hz,
        .rotor_angle, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_pwm_out,
        .phase_oe, .standby, .sleep, .init_req, .amplitude, .handoff_speed, .reverse_dir
    );

    fan_host_model host (
        .clk, .rst_n, .period(16'h01F4), .high_cnt, .float_en, .command_in
    );

    always #10 clk = ~clk;

    always @(posedge clk) begin
        rotor_angle <= hold_angle ? 7'h00 : 7'($urandom % 96);
    end

    function automatic int exp_code(input int hi);
        return (hi * 512 / 500 > 511) ? 511 : hi * 512 / 500;
    endfunction : exp_code

    function automatic int exp_amp(input int hi);
        int c;
        c = exp_code(hi);
        return (c == 0) ? 0 : (c < 51) ? 51 : c;
    endfunction : exp_amp

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask : reg_read

    task automatic conclude();
        $display("Mismatches %0d, checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        cyc(90000);
        mismatches++;
        conclude();
    end

    // ======================================================================
    // Scenarios
    // ======================================================================
    initial begin
        void'($urandom(32'h404DD4F1));
        cyc(4);
        rst_n <= 1'b1;
        reg_read(4'h0, rd);
        `CHK(rd, 32'h1)
        reg_read(4'h2, rd);
        `CHK(rd, 32'h0)
        reg_read(4'h4, rd);
        `CHK(rd[3:0], 4'h2)
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            handoff_level <= 8'(k * 16 + $urandom % 16);
            cyc(2);
            @(negedge clk);
            `CHK(handoff_speed, (k == 0) ? LOW : 11'(k * 125))
        end
        // Static high needs the full period timeout before it reads as 100%
        cyc(4400);
        reg_read(4'h8, rd);
        `CHK(rd[24:16], 9'h1FF)
        high_cnt <= 16'h01F3;
        cyc(15000);
        @(negedge clk);
        `CHK(amplitude, exp_amp(499))
        hold_angle <= 1'b1;
        cyc(2100);
        p = 1'b1;
        g = 0;
        t = 0;
        repeat (6000) begin
            @(negedge clk);
            if (phase_pwm_out[0] === 1'b1 && p === 1'b0) begin
                if (t > 0) `CHK(g, 2000)
                t++;
                g = 0;
            end
            g++;
            p = phase_pwm_out[0];
        end
        `CHK(t > 1, 1'b1)
        @(posedge clk);
        reg_write(4'h0, 32'h0);
        cyc(3);
        @(negedge clk);
        `CHK(phase_oe, 3'h0)
        @(posedge clk);
        reg_write(4'h0, 32'h1);
        hold_angle <= 1'b0;
        h = 60 + $urandom % 380;
        high_cnt <= 16'(h);
        cyc(1530);
        @(negedge clk);
        `CHK(amplitude > exp_amp(h) && amplitude < 9'h1FE, 1'b1)
        cyc(15000);
        @(negedge clk);
        `CHK(amplitude, exp_amp(h))
        reg_read(4'h8, rd);
        `CHK(rd[24:16], exp_code(h))
        high_cnt <= 16'h0014;
        cyc(15000);
        @(negedge clk);
        `CHK(amplitude, exp_amp(20))
        @(posedge clk);
        high_cnt <= 16'h0001;
        cyc(2000);
        @(negedge clk);
        `CHK({standby, phase_oe}, 4'h8)
        reg_read(4'h4, rd);
        `CHK(rd[5:0], 6'h24)
        high_cnt <= 16'h0000;
        cyc(600);
        @(negedge clk);
        `CHK(sleep, 1'b0)
        @(posedge clk);
        motor_below_10hz <= 1'b1;
        for (k = 0; k < 50 && sleep !== 1'b1; k++) @(negedge clk);
        `CHK({sleep, phase_oe}, 4'h8)
        @(posedge clk);
        rotation_select <= 1'b1;
        cyc(20);
        @(negedge clk);
        `CHK(sleep, 1'b1)
        @(posedge clk);
        float_en <= 1'b1;
        for (k = 0; k < 10 && init_req !== 1'b1; k++) @(negedge clk);
        `CHK(init_req, 1'b1)
        cyc(3);
        @(negedge clk);
        `CHK(reverse_dir, 1'b1)
        @(posedge clk);
        rotation_select <= 1'b0;
        // Wake edge closes a long low period: standby until the static timeout
        cyc(4200);
        reg_read(4'h4, rd);
        `CHK(rd[4:0], 5'h12)
        conclude();
    end
endmodule : fan_speed_command_decoder_bench
`default_nettype wire
